// [src/npla_pkg.sv]
// Package of constants for the network pressure limit allocator.
// Assumes it is compiled before any design file that names it.
`default_nettype none

package npla_pkg;

   // ***************************************************************
   // Register map (byte addresses on APB).
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL    = 8'h00;  // Mode, reconfig, run, node id.
   localparam logic [7:0] ADDR_ROTINT  = 8'h04;  // Rotation interval in seconds.
   localparam logic [7:0] ADDR_REMAIN  = 8'h08;  // Rotation time remaining (read, write restores).
   localparam logic [7:0] ADDR_ACTIVE  = 8'h0c;  // Per-compressor active bits.
   localparam logic [7:0] ADDR_PRESS   = 8'h10;  // Measured network pressure.
   localparam logic [7:0] ADDR_STATUS  = 8'h14;  // Run state and compressor on bits.
   localparam logic [7:0] ADDR_BAND0   = 8'h20;  // Band table, one word per band.
   localparam logic [7:0] ADDR_ASSIGN  = 8'h30;  // Band index per compressor, read only.

   // ***************************************************************
   // Control field positions.
   // ***************************************************************
   localparam int CTRL_MODE_BIT  = 0;   // 1 selects the sequential algorithm.
   localparam int CTRL_RECFG_BIT = 1;   // 1 enables automatic reconfiguration.
   localparam int CTRL_RUN_BIT   = 2;   // 1 runs network operation.
   localparam int CTRL_ID_LSB    = 8;   // Node identifier field, 3 bits.
   localparam int ID_W           = 3;
   localparam logic [2:0] ID_MIN = 3'h1;
   localparam logic [2:0] ID_MAX = 3'h4;

   // ***************************************************************
   // Timing.
   // ***************************************************************
   localparam int CLOCK_HZ       = 20000000;  // System clock rate.
   localparam int SECOND_S       = 1;         // Countdown tick unit in seconds.
   localparam int TICK_CYCLES    = CLOCK_HZ * SECOND_S;
   localparam logic [31:0] ROTINT_RESET = 32'h0000_0e10;  // One hour.
endpackage : npla_pkg

`default_nettype wire

// [src/npla_allocator.sv]
// Network pressure limit allocator: band assignment, rotation and hysteresis.
// Assumes an APB master on the same clock and that the held countdown
// value is restored by software from retained storage after power loss.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`default_nettype none

// Summary of operation
// RULE1 - Sequential mode rotates bands every interval.
// RULE2 - Countdown runs only while network runs.
// RULE3 - Stop holds countdown; restart resumes it.
// RULE4 - Held countdown survives power loss.
// RULE5 - Rotation never forces a compressor off.
// RULE6 - Only active compressors join rotation.
// RULE7 - Sequential reconfig: stopped unit gets lowest band.
// RULE8 - Inactive unit stays lowest across rotations.
// RULE9 - Cascade binds bands to ids, no rotation.
// RULE10 - Cascade reconfig: stopped lowest, others shift.
// RULE11 - Cascade restores original bands on return.
// RULE12 - On below lower limit, off at upper.
// RULE13 - Software should program stepped bands.
// RULE14 - Node joins only with id one to four.
// RULE15 - Rotation moves bands up, top wraps lowest.
// RULE16 - Zero countdown rotates and reloads interval.
module npla_allocator #(
   parameter int N       = 4,
   parameter int PW      = 16,
   parameter int TICK    = npla_pkg::TICK_CYCLES
) (
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   output logic      [N-1:0]  compressorOn,
   output logic      [31:0]   rotationTimeRemaining
);

   // ***************************************************************
   // Elaboration checks.
   // ***************************************************************
   if (N != 4) begin : g_bad_n $error("N must be 4: band index fields are two bits."); end
   if (PW < 1 || PW > 16) begin : g_bad_pw $error("PW must be 1 to 16."); end
   if (TICK < 1) begin : g_bad_tick $error("TICK must be at least 1."); end

   // ***************************************************************
   // Reset synchroniser.
   // ***************************************************************
   logic rstMeta_q;  // First stage, read only by the second.
   logic rstSync_q;  // Released reset, active low.
   logic rstN;       // Reset used by the rest of the design.

   // Two flops release reset cleanly against the clock.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end
   assign rstN = rstSync_q;

   // ***************************************************************
   // Registers and state.
   // ***************************************************************
   logic              seqMode_q,  seqMode_d;   // Sequential algorithm select.
   logic              recfg_q,    recfg_d;     // Automatic reconfiguration.
   logic              run_q,      run_d;       // Network operation running.
   logic [2:0]        nodeId_q,   nodeId_d;    // Own node identifier.
   logic [31:0]       rotInt_q,   rotInt_d;    // Rotation interval, seconds.
   logic [31:0]       remain_q,   remain_d;    // Rotation time remaining.
   logic [N-1:0]      active_q,   active_d;    // Compressor active bits.
   logic [PW-1:0]     press_q,    press_d;     // Measured pressure.
   logic [PW-1:0]     bandLo_q [N];            // Lower limit per band.
   logic [PW-1:0]     bandHi_q [N];            // Upper limit per band.
   logic [PW-1:0]     bandLo_d [N];
   logic [PW-1:0]     bandHi_d [N];
   logic [1:0]        rank_q [N];              // Sequential band per compressor.
   logic [1:0]        rank_d [N];
   logic [1:0]        assign_w [N];            // Band in effect per compressor.
   logic [N-1:0]      on_q,       on_d;        // Compressor running.
   logic [31:0]       tick_q,     tick_d;      // Second prescaler.
   logic [31:0]       rdata_d;
   logic              err_d;
   logic              netOk;                   // Node may take part.
   logic              secondTick;              // One pulse per second.
   logic              rotate;                  // Rotation pulse.

   wire busWr = psel && penable && pwrite;
   // Read setup: data is registered here so it stands through the access cycle.
   wire busRd = psel && !penable && !pwrite;

   // A node with an identifier outside 1..4 sits out of the network. [RULE14]
   assign netOk = (nodeId_q >= npla_pkg::ID_MIN) && (nodeId_q <= npla_pkg::ID_MAX);

   // ***************************************************************
   // Countdown and rotation timing.
   // ***************************************************************
   // The prescaler and the countdown advance only while running; on stop the
   // value is simply held, so restart resumes it. [RULE2] [RULE3]
   always_comb begin
      tick_d     = tick_q;
      secondTick = 1'b0;
      remain_d   = remain_q;
      rotate     = 1'b0;
      if (run_q && netOk) begin
         if (tick_q == 32'(TICK - 1)) begin
            tick_d     = 32'h0;
            secondTick = 1'b1;
         end else begin
            tick_d = tick_q + 32'h1;
         end
      end
      // Cascade mode never counts: the interval is ignored there. [RULE9]
      if (secondTick && seqMode_q) begin
         if (remain_q <= 32'h1) begin
            rotate   = 1'b1;       // [RULE1] [RULE16]
            remain_d = rotInt_q;   // [RULE16]
         end else begin
            remain_d = remain_q - 32'h1;  // [RULE2]
         end
      end
      // Software restores the retained value after power loss. [RULE4]
      if (busWr && paddr == npla_pkg::ADDR_REMAIN) remain_d = pwdata;
   end

   // ***************************************************************
   // Sequential band ranks.
   // ***************************************************************
   // Rank 0 is the lowest band. An inactive unit is pinned to the lowest
   // ranks and the active ones shift up to fill what it left. [RULE7] [RULE8]
   always_comb begin
      logic [1:0] nAct;
      logic [1:0] k;
      nAct = 2'h0;
      k    = 2'h0;
      for (int i = 0; i < N; i++) rank_d[i] = rank_q[i];
      for (int i = 0; i < N; i++) if (active_q[i]) nAct = nAct + 2'h1;
      if (seqMode_q && recfg_q) begin
         // Inactive units take lowest ranks; active keep relative order. [RULE6]
         for (int i = 0; i < N; i++) if (!active_q[i]) begin
            rank_d[i] = k;
            k = k + 2'h1;
         end
         for (int r = 0; r < N; r++)
            for (int i = 0; i < N; i++)
               if (active_q[i] && rank_q[i] == 2'(r)) begin
                  rank_d[i] = k;
                  k = k + 2'h1;
               end
      end
      if (rotate) begin
         // Active bands step up one; the top one wraps to the lowest
         // active band. Inactive ranks are left alone. [RULE15] [RULE6]
         for (int i = 0; i < N; i++) begin
            if (active_q[i] && nAct != 2'h0) begin
               if (rank_d[i] == 2'(N - 1)) rank_d[i] = 2'(N) - nAct;  // wrap
               else rank_d[i] = rank_d[i] + 2'h1;
            end
         end
         if (active_q == {N{1'b1}}) begin
            for (int i = 0; i < N; i++) rank_d[i] = rank_q[i] + 2'h1;
         end
      end
      if (!seqMode_q) for (int i = 0; i < N; i++) rank_d[i] = 2'(N - 1 - i);
   end

   // ***************************************************************
   // Cascade assignment and band in effect.
   // ***************************************************************
   // Cascade: compressor i owns band by id; with reconfiguration a stopped
   // unit drops to lowest and those below it move up one. [RULE9] [RULE10]
   // Once restored, the plain id mapping returns. [RULE11]
   always_comb begin
      logic [1:0] k;
      k = 2'h0;
      for (int i = 0; i < N; i++) assign_w[i] = rank_q[i];
      if (!seqMode_q) begin
         for (int i = 0; i < N; i++) assign_w[i] = 2'(N - 1 - i);
         if (recfg_q) begin
            k = 2'h0;
            for (int i = 0; i < N; i++) if (!active_q[i]) begin
               assign_w[i] = k;
               k = k + 2'h1;
            end
            for (int r = 0; r < N; r++)
               for (int i = 0; i < N; i++)
                  if (active_q[i] && (N - 1 - i) == r) begin
                     assign_w[i] = k;
                     k = k + 2'h1;
                  end
         end
      end
   end

   // ***************************************************************
   // Compressor hysteresis.
   // ***************************************************************
   // Each unit starts below its band's lower limit and stops at its upper.
   // A rotation only changes limits; it forces nothing off. [RULE12] [RULE5]
   always_comb begin
      for (int i = 0; i < N; i++) begin
         on_d[i] = on_q[i];
         if (!run_q || !netOk || !active_q[i]) on_d[i] = 1'b0;
         else if (press_q < bandLo_q[assign_w[i]]) on_d[i] = 1'b1;
         else if (press_q >= bandHi_q[assign_w[i]]) on_d[i] = 1'b0;
      end
   end

   // ***************************************************************
   // Register file next state and read mux.
   // ***************************************************************
   // Unmapped addresses answer with pslverr and read zero.
   always_comb begin
      seqMode_d = seqMode_q;
      recfg_d   = recfg_q;
      run_d     = run_q;
      nodeId_d  = nodeId_q;
      rotInt_d  = rotInt_q;
      active_d  = active_q;
      press_d   = press_q;
      for (int i = 0; i < N; i++) begin
         bandLo_d[i] = bandLo_q[i];
         bandHi_d[i] = bandHi_q[i];
      end
      rdata_d = 32'h0;
      err_d   = 1'b0;
      unique case (paddr)
         npla_pkg::ADDR_CTRL: begin
            if (busWr) begin
               seqMode_d = pwdata[npla_pkg::CTRL_MODE_BIT];
               recfg_d   = pwdata[npla_pkg::CTRL_RECFG_BIT];
               run_d     = pwdata[npla_pkg::CTRL_RUN_BIT];
               nodeId_d  = pwdata[npla_pkg::CTRL_ID_LSB +: npla_pkg::ID_W];
            end
            rdata_d[npla_pkg::CTRL_MODE_BIT]  = seqMode_q;
            rdata_d[npla_pkg::CTRL_RECFG_BIT] = recfg_q;
            rdata_d[npla_pkg::CTRL_RUN_BIT]   = run_q;
            rdata_d[npla_pkg::CTRL_ID_LSB +: npla_pkg::ID_W] = nodeId_q;
         end
         npla_pkg::ADDR_ROTINT: begin
            if (busWr) rotInt_d = pwdata;
            rdata_d = rotInt_q;
         end
         npla_pkg::ADDR_REMAIN: rdata_d = remain_q;
         npla_pkg::ADDR_ACTIVE: begin
            if (busWr) active_d = pwdata[N-1:0];
            rdata_d[N-1:0] = active_q;
         end
         npla_pkg::ADDR_PRESS: begin
            if (busWr) press_d = pwdata[PW-1:0];
            rdata_d[PW-1:0] = press_q;
         end
         npla_pkg::ADDR_STATUS: begin
            rdata_d[0]     = run_q && netOk;
            rdata_d[N:1]   = on_q;
         end
         npla_pkg::ADDR_ASSIGN: begin
            for (int i = 0; i < N; i++) rdata_d[2*i +: 2] = assign_w[i];
         end
         default: begin
            if (paddr >= npla_pkg::ADDR_BAND0 && paddr < npla_pkg::ADDR_BAND0 + 8'(4 * N)
                && paddr[1:0] == 2'h0) begin
               if (busWr) begin
                  bandLo_d[paddr[3:2]] = pwdata[PW-1:0];
                  bandHi_d[paddr[3:2]] = pwdata[16 +: PW];
               end
               rdata_d[PW-1:0]   = bandLo_q[paddr[3:2]];
               rdata_d[16 +: PW] = bandHi_q[paddr[3:2]];
            end else begin
               err_d = 1'b1;
            end
         end
      endcase
      if (!busRd) rdata_d = prdata;
   end

   assign pready  = 1'b1;  // Zero wait states.
   assign pslverr = psel && penable && err_d;

   // ***************************************************************
   // State registers.
   // ***************************************************************
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         seqMode_q <= 1'b0;
         recfg_q   <= 1'b0;
         run_q     <= 1'b0;
         nodeId_q  <= 3'h0;
         rotInt_q  <= npla_pkg::ROTINT_RESET;
         remain_q  <= npla_pkg::ROTINT_RESET;
         active_q  <= '0;
         press_q   <= '0;
         on_q      <= '0;
         tick_q    <= 32'h0;
         prdata    <= 32'h0;
         for (int i = 0; i < N; i++) begin
            bandLo_q[i] <= '0;
            bandHi_q[i] <= '0;
            rank_q[i]   <= 2'(N - 1 - i);
         end
      end else begin
         seqMode_q <= seqMode_d;
         recfg_q   <= recfg_d;
         run_q     <= run_d;
         nodeId_q  <= nodeId_d;
         rotInt_q  <= rotInt_d;
         remain_q  <= remain_d;
         active_q  <= active_d;
         press_q   <= press_d;
         on_q      <= on_d;
         tick_q    <= tick_d;
         prdata    <= rdata_d;
         for (int i = 0; i < N; i++) begin
            bandLo_q[i] <= bandLo_d[i];
            bandHi_q[i] <= bandHi_d[i];
            rank_q[i]   <= rank_d[i];
         end
      end
   end

   assign compressorOn          = on_q;
   assign rotationTimeRemaining = remain_q;

   // ***************************************************************
   // Assertions.
   // ***************************************************************
   count_hold_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE3]
      (!run_q && !busWr) |=> remain_q == $past(remain_q))
      else $error("Countdown moved while stopped.");
   count_reload_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE16]
      (rotate && !busWr) |=> remain_q == $past(rotInt_q))
      else $error("Countdown not reloaded.");
   casc_norot_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE9]
      !seqMode_q |-> !rotate)
      else $error("Rotation in cascade mode.");
   id_gate_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE14]
      !netOk |=> on_q == '0)
      else $error("Compressor on with bad id.");
   switch_on_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE12]
      (run_q && netOk && active_q[0] && press_q < bandLo_q[assign_w[0]]) |=> on_q[0])
      else $error("Compressor did not start below lower limit.");
   inact_off_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE6]
      !active_q[1] |=> !on_q[1])
      else $error("Inactive compressor running.");
   casc_low_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE10]
      (!seqMode_q && recfg_q && active_q == 4'he) |-> assign_w[0] == 2'h0)
      else $error("Stopped unit not at lowest band.");
   casc_restore_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE11]
      (!seqMode_q && active_q == {N{1'b1}}) |-> assign_w[2] == 2'h1)
      else $error("Cascade band not restored.");
   rot_count_a: assert property (@(posedge clock) disable iff (!rstN)  // [RULE2]
      (secondTick && seqMode_q && remain_q > 32'h1 && !busWr) |=> remain_q == $past(remain_q) - 32'h1)
      else $error("Countdown step wrong.");

endmodule : npla_allocator

`default_nettype wire

// [bench/npla_compressor_bank.sv]
// Behavioural model of the slave compressors that obey the run commands.
// Assumes the run command bits arrive registered on the system clock.
`default_nettype none

module npla_compressor_bank (
   input  wire logic       clock,
   input  wire logic [3:0] compressorOn,
   output logic      [2:0] runningCount
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Running units.
   // ***************************************************************
   // Each slave follows its command one clock late, as a remote unit would.
   // The bench reads the count only after the commands have settled.
   always_ff @(posedge clock) begin
      runningCount <= 3'(compressorOn[0]) + 3'(compressorOn[1]) + 3'(compressorOn[2]) + 3'(compressorOn[3]);
   end
endmodule : npla_compressor_bank

`default_nettype wire

// [bench/npla_allocator_tb_top.sv]
// Self-checking bench for the pressure limit allocator over APB.
// Assumes a shortened seconds tick (TICK=4) and a zero-wait APB slave.
`default_nettype none

`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module npla_allocator_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Stimulus and observed signals.
   // ***************************************************************
   logic        clock;                  // System clock, 50 ns.
   logic        nrst;                   // Active-low reset.
   logic        psel, penable, pwrite;  // APB control.
   logic [7:0]  paddr;                  // APB address.
   logic [31:0] pwdata, prdata;         // APB data.
   logic        pready, pslverr;        // APB answer.
   logic [3:0]  compressorOn;           // Run commands.
   logic [31:0] rotationTimeRemaining;  // Countdown shown for display.
   logic [2:0]  runningCount;           // Units running in the model.
   int          errors, totalChecks;    // Mismatch and comparison counters.

   npla_allocator #(.N(4), .PW(16), .TICK(4)) dut_u (
      .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compressorOn(compressorOn), .rotationTimeRemaining(rotationTimeRemaining));

   npla_compressor_bank bank_u (.clock(clock), .compressorOn(compressorOn), .runningCount(runningCount));

   // ***************************************************************
   // Clock, closing report and watchdog.
   // ***************************************************************
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // A hang anywhere is cut here and counted as a mismatch.
   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      end_of_test();
   end

   // ***************************************************************
   // APB master and helpers.
   // ***************************************************************
   // One transfer: setup, then access held until pready is seen high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin errors++; end_of_test(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd

   // Control word: bit0 sequential, bit1 reconfiguration, bit2 run, bits 10:8 node id.
   function automatic logic [31:0] ctl(input logic sq, input logic rc, input logic run, input logic [2:0] id);
      return {21'h0, id, 5'h0, run, rc, sq};
   endfunction : ctl

   function automatic logic [1:0] fld(input logic [31:0] a, input int i);
      return a[2*i +: 2];
   endfunction : fld

   // Bounded waits; wait_remain ends the run as a failure when it runs out, wait_on only records a mismatch.
   task automatic wait_remain(input logic [31:0] v);
      int k;
      for (k = 0; k < 300 && rotationTimeRemaining !== v; k++) @(posedge clock);
      if (k == 300) begin errors++; end_of_test(); end
   endtask : wait_remain

   task automatic wait_on(input logic [3:0] v);
      int k;
      for (k = 0; k < 50 && compressorOn !== v; k++) @(posedge clock);
      `CHK(compressorOn, v)
   endtask : wait_on

   // ***************************************************************
   // Scenarios.
   // ***************************************************************
   // Reset values, unmapped access, stepped bands and node id range.
   task automatic t_setup();
      logic [31:0] r;
      logic e;
      `CHK(rotationTimeRemaining, 32'h0000_0e10)
      rd(npla_pkg::ADDR_ROTINT, r); `CHK(r, 32'h0000_0e10)
      apb(1'b0, 8'h40, 32'h0, r, e); `CHK({e, r}, 33'h1_0000_0000)
      for (int k = 0; k < 4; k++) begin
         wr(8'(npla_pkg::ADDR_BAND0 + 8'(4 * k)), {16'(12'h410 + 12'(k * 256)), 16'(12'h300 + 12'(k * 256))});
      end
      wr(npla_pkg::ADDR_ACTIVE, 32'h0000_000f);
      for (int id = 0; id < 6; id++) begin
         wr(npla_pkg::ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1, 3'(id)));
         rd(npla_pkg::ADDR_STATUS, r);
         `CHK(r[0], 1'((id >= 1) && (id <= 4)))
      end
      $display("test setup done");
   endtask : t_setup

   // Cascade: fixed bands, no rotation, reconfiguration and restore.
   task automatic t_cascade();
      logic [31:0] r;
      wr(npla_pkg::ADDR_CTRL, ctl(1'b0, 1'b1, 1'b1, 3'h1));
      wr(npla_pkg::ADDR_REMAIN, 32'h1);
      repeat (40) @(posedge clock);
      rd(npla_pkg::ADDR_ASSIGN, r); `CHK(r[7:0], 8'h1b)
      wr(npla_pkg::ADDR_PRESS, 32'h0200); wait_on(4'hf);
      `CHK(runningCount, 3'h4)
      wr(npla_pkg::ADDR_PRESS, 32'h0500); wait_on(4'h7);
      wr(npla_pkg::ADDR_PRESS, 32'h0800); wait_on(4'h0);
      wr(npla_pkg::ADDR_PRESS, 32'h0550); wait_on(4'h1);
      wr(npla_pkg::ADDR_ACTIVE, 32'hd);
      rd(npla_pkg::ADDR_ASSIGN, r); `CHK(r[7:0], 8'h63)
      wr(npla_pkg::ADDR_ACTIVE, 32'hf);
      rd(npla_pkg::ADDR_ASSIGN, r); `CHK(r[7:0], 8'h1b)
      $display("test cascade done");
   endtask : t_cascade

   // Sequential: rotation step, hold on stop, restore and resume.
   task automatic t_rotate();
      logic [31:0] a0, a1, v;
      wr(npla_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h1));
      wr(npla_pkg::ADDR_PRESS, 32'h0200);
      wr(npla_pkg::ADDR_ROTINT, 32'h5);
      wr(npla_pkg::ADDR_REMAIN, 32'h2);
      rd(npla_pkg::ADDR_ASSIGN, a0);
      wr(npla_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b1, 3'h1));
      wait_on(4'hf);
      wait_remain(32'h5);
      rd(npla_pkg::ADDR_ASSIGN, a1);
      for (int i = 0; i < 4; i++) `CHK(fld(a1, i), 2'(fld(a0, i) + 2'h1))
      `CHK(compressorOn, 4'hf)
      wr(npla_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, 3'h1));
      @(posedge clock);
      v = rotationTimeRemaining;
      repeat (40) @(posedge clock);
      `CHK(rotationTimeRemaining, v)
      wr(npla_pkg::ADDR_REMAIN, 32'h7);
      rd(npla_pkg::ADDR_REMAIN, v); `CHK(v, 32'h7)
      wr(npla_pkg::ADDR_CTRL, ctl(1'b1, 1'b0, 1'b1, 3'h1));
      wait_remain(32'h6);
      `CHK(rotationTimeRemaining, 32'h6)
      $display("test rotate done");
   endtask : t_rotate

   // Sequential reconfiguration: idle unit parked on the lowest band.
   task automatic t_seq_recfg();
      logic [31:0] a1, a2;
      wr(npla_pkg::ADDR_ACTIVE, 32'hd);
      wr(npla_pkg::ADDR_CTRL, ctl(1'b1, 1'b1, 1'b1, 3'h1));
      rd(npla_pkg::ADDR_ASSIGN, a1);
      `CHK(fld(a1, 1), 2'h0)
      `CHK(4'(fld(a1, 0)) + 4'(fld(a1, 2)) + 4'(fld(a1, 3)), 4'h6)
      wr(npla_pkg::ADDR_REMAIN, 32'h1);
      wait_remain(32'h5);
      rd(npla_pkg::ADDR_ASSIGN, a2);
      `CHK(fld(a2, 1), 2'h0)
      `CHK(4'(fld(a2, 0)) + 4'(fld(a2, 2)) + 4'(fld(a2, 3)), 4'h6)
      `CHK(a2[7:0] != a1[7:0], 1'b1)
      $display("test sequential reconfiguration done");
   endtask : t_seq_recfg

   // ***************************************************************
   // Main sequence.
   // ***************************************************************
   initial begin
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; errors = 0; totalChecks = 0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      t_setup();
      t_cascade();
      t_rotate();
      t_seq_recfg();
      end_of_test();
   end
endmodule : npla_allocator_tb_top

`default_nettype wire
